/* hdl/cpu_clock_defines.svh */
`ifndef CPU_CLOCK_DEFINES_SVH
`define CPU_CLOCK_DEFINES_SVH

// ----------------------------------------
// Configuration field layout
// ----------------------------------------
`define PORT_BYTE_W 8
`define CLK_SEL_MSB 7
`define CLK_SEL_LSB 5
`define CLK_SEL_W 3
`define CLK_SEL_MODE_BIT 2
`define CONFIG_RESET_VALUE 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define OSC_PERIOD_NS 50
`define CLK_PERIOD_NS 50
`define PRESCALE_PHASE_CYCLES (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define PHASE_CNT_W 2
`define SYNC_STAGES 2
`define CAPTURE_EDGES 3

`endif

/* hdl/cpu_clock_pkg.sv */
package cpu_clock_pkg;
   typedef enum logic {
      MODE_DIRECT,
      MODE_PRESCALE
   } clk_mode_e;
endpackage

/* hdl/cpu_clock_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface cpu_clock_if;
   logic riseEn;
   logic fallEn;
   logic level;

   modport gen (
      output riseEn,
      output fallEn,
      output level
   );
   modport use_side (
      input riseEn,
      input fallEn,
      input level
   );
endinterface

`default_nettype wire

/* hdl/cpu_phase_gen.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_clock_defines.svh"

module cpu_phase_gen
   import cpu_clock_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire clk_mode_e mode,
   cpu_clock_if.gen cpuClk
);

   logic [`PHASE_CNT_W-1:0] phaseCnt;
   logic phaseDone;
   logic level;

   assign phaseDone = (phaseCnt == `PHASE_CNT_W'(`PRESCALE_PHASE_CYCLES - 1));

   // ----------------------------------------
   // Phase length counter
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst || phaseDone || mode == MODE_DIRECT) begin
         phaseCnt <= '0;
      end else begin
         phaseCnt <= phaseCnt + `PHASE_CNT_W'(1);
      end
   end

   // ----------------------------------------
   // CPU clock level
   // ----------------------------------------
   // Divider toggles once per oscillator period in prescale mode, so duty is even; direct drive holds level high
   always_ff @(posedge clk) begin
      if (rst) begin
         level <= 1'b0;
      end else if (mode == MODE_PRESCALE) begin
         if (phaseDone) begin
            level <= ~level;
         end
      end else begin
         level <= 1'b1;
      end
   end

   // Direct drive: both edges fall in every oscillator period
   always_comb begin
      if (rst) begin
         cpuClk.riseEn = 1'b0;
         cpuClk.fallEn = 1'b0;
      end else if (mode == MODE_DIRECT) begin
         cpuClk.riseEn = 1'b1;
         cpuClk.fallEn = 1'b1;
      end else begin
         cpuClk.riseEn = phaseDone && !level;
         cpuClk.fallEn = phaseDone && level;
      end
   end

   assign cpuClk.level = level;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence inPrescale;
      mode == MODE_PRESCALE;
   endsequence

   sequence alternates;
      (cpuClk.riseEn != cpuClk.fallEn) ##1 (cpuClk.riseEn == $past(cpuClk.fallEn));
   endsequence

   AST_PRESCALE_HALF: assert property (@(posedge clk) disable iff (rst)
      !rst ##0 inPrescale |=> level != $past(level))
      else $error("prescaler phase did not last one oscillator period");

   AST_PRESCALE_ALT: assert property (@(posedge clk) disable iff (rst)
      inPrescale ##1 inPrescale |-> alternates)
      else $error("prescaler edges do not alternate");

   AST_DIRECT_TWO_PHASES: assert property (@(posedge clk) disable iff (rst)
      !rst && mode == MODE_DIRECT |-> cpuClk.riseEn && cpuClk.fallEn)
      else $error("direct drive period does not hold two phases");

endmodule

`default_nettype wire

/* hdl/cpu_clock_mode_select.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_clock_defines.svh"

module cpu_clock_mode_select
   import cpu_clock_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [`PORT_BYTE_W-1:0] port0UpperByte,
   output logic [`PORT_BYTE_W-1:0] resetConfigUpperByte,
   output logic [`CLK_SEL_W-1:0] clockSourceSelect,
   output logic prescalerMode,
   output logic cpuClockLevel,
   output logic cpuRiseEn,
   output logic cpuFallEn,
   output logic [`PHASE_CNT_W-1:0] phaseSteps
);

   logic [`PORT_BYTE_W-1:0] pinMeta;
   logic [`PORT_BYTE_W-1:0] pinSync;
   clk_mode_e mode;

   cpu_clock_if cpuClk ();

   function automatic clk_mode_e decodeMode(input logic [`CLK_SEL_W-1:0] sel);
      decodeMode = sel[`CLK_SEL_MODE_BIT] ? MODE_PRESCALE : MODE_DIRECT;
   endfunction

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   always_ff @(posedge clk) begin
      pinMeta <= port0UpperByte;
      pinSync <= pinMeta;
   end

   // ----------------------------------------
   // Reset configuration capture
   // ----------------------------------------
   // Sampled every cycle of reset; last value before release is kept
   always_ff @(posedge clk) begin
      if (rst) begin
         resetConfigUpperByte <= pinSync;
      end
   end

   assign clockSourceSelect = resetConfigUpperByte[`CLK_SEL_MSB:`CLK_SEL_LSB];
   assign mode = decodeMode(clockSourceSelect);

   always_ff @(posedge clk) begin
      if (rst) begin
         prescalerMode <= 1'b0;
      end else begin
         prescalerMode <= (decodeMode(clockSourceSelect) == MODE_PRESCALE);
      end
   end

   // ----------------------------------------
   // Phase generator
   // ----------------------------------------
   cpu_phase_gen phaseGen (
      .clk(clk),
      .rst(rst),
      .mode(mode),
      .cpuClk(cpuClk)
   );

   assign cpuRiseEn = cpuClk.riseEn;
   assign cpuFallEn = cpuClk.fallEn;
   assign cpuClockLevel = cpuClk.level;
   assign phaseSteps = {1'b0, cpuClk.riseEn} + {1'b0, cpuClk.fallEn};

   // ----------------------------------------
   // Check helpers
   // ----------------------------------------
   // Run lengths of each clock level; saturating so direct drive cannot wrap
   logic [`PHASE_CNT_W-1:0] highRun;
   logic [`PHASE_CNT_W-1:0] lowRun;

   always_ff @(posedge clk) begin
      if (rst || !cpuClockLevel) begin
         highRun <= '0;
      end else if (highRun != '1) begin
         highRun <= highRun + `PHASE_CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst || cpuClockLevel) begin
         lowRun <= '0;
      end else if (lowRun != '1) begin
         lowRun <= lowRun + `PHASE_CNT_W'(1);
      end
   end

   // ----------------------------------------
   // Check sequences
   // ----------------------------------------
   // Two reset edges first, so the synchroniser no longer holds unknowns
   sequence inReset;
      rst ##1 rst;
   endsequence

   sequence heldReset;
      rst ##1 rst ##1 rst;
   endsequence

   sequence running;
      !rst ##1 !rst;
   endsequence

   // Sampled rst here, since release lands on the very edge being checked
   sequence prescaleRun;
      !rst ##0 clockSourceSelect[`CLK_SEL_MODE_BIT];
   endsequence

   sequence directRun;
      !rst ##0 !clockSourceSelect[`CLK_SEL_MODE_BIT];
   endsequence

   // ----------------------------------------
   // Capture and hold checks
   // ----------------------------------------
   AST_CAPTURE: assert property (@(posedge clk) disable iff (1'b0)
      inReset |=> clockSourceSelect == $past(pinSync[`CLK_SEL_MSB:`CLK_SEL_LSB]))
      else $error("select field not captured from pins during reset");

   AST_CAPTURE_PINS: assert property (@(posedge clk) disable iff (1'b0)
      heldReset |=> resetConfigUpperByte == $past(port0UpperByte, `CAPTURE_EDGES))
      else $error("captured byte differs from the pins three edges earlier");

   AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (rst)
      running |-> pinSync == $past(port0UpperByte, `SYNC_STAGES))
      else $error("pin synchroniser delay is not two edges");

   AST_MODE_HELD: assert property (@(posedge clk) disable iff (rst)
      running |-> $stable(resetConfigUpperByte))
      else $error("clock mode changed outside reset");

   AST_SELECT_HELD: assert property (@(posedge clk) disable iff (rst)
      running |-> $stable(clockSourceSelect))
      else $error("select field changed outside reset");

   AST_PINS_IGNORED: assert property (@(posedge clk) disable iff (rst)
      running ##0 $changed(port0UpperByte) |=> $stable(resetConfigUpperByte))
      else $error("pin change reached the captured byte outside reset");

   AST_PRESCALE_FLAG: assert property (@(posedge clk) disable iff (rst)
      running |-> prescalerMode == clockSourceSelect[`CLK_SEL_MODE_BIT])
      else $error("prescaler flag disagrees with select field");

   AST_RESET_FLAGS: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> !prescalerMode && !cpuClockLevel)
      else $error("prescaler flag or clock level not cleared in reset");

   // ----------------------------------------
   // Phase checks
   // ----------------------------------------
   AST_RESET_QUIET: assert property (@(posedge clk) disable iff (1'b0)
      rst |-> !cpuRiseEn && !cpuFallEn && phaseSteps == 2'h0)
      else $error("clock edge enabled during reset");

   AST_DIRECT_MODE: assert property (@(posedge clk) disable iff (rst)
      running ##0 directRun |-> cpuRiseEn && cpuFallEn && cpuClockLevel)
      else $error("direct drive not selected for top bit zero");

   AST_DIRECT_FIRST: assert property (@(posedge clk) disable iff (1'b0)
      rst ##1 directRun |-> cpuRiseEn && cpuFallEn)
      else $error("direct drive edges missing in first cycle after reset");

   AST_DIRECT_STEPS: assert property (@(posedge clk) disable iff (rst)
      directRun |-> phaseSteps == 2'h2)
      else $error("direct drive period does not hold two phases");

   AST_PRESCALE_MODE: assert property (@(posedge clk) disable iff (rst)
      prescaleRun |-> cpuRiseEn != cpuFallEn)
      else $error("prescaler not selected for top bit one");

   AST_PRESCALE_FIRST: assert property (@(posedge clk) disable iff (1'b0)
      rst ##1 prescaleRun |-> cpuRiseEn)
      else $error("first prescaler edge after reset is not a rise");

   AST_PRESCALE_STEPS: assert property (@(posedge clk) disable iff (rst)
      prescaleRun |-> phaseSteps == 2'h1)
      else $error("prescaler period does not hold one phase");

   AST_PHASE_STEP: assert property (@(posedge clk) disable iff (rst)
      !rst |-> phaseSteps != 2'h0)
      else $error("oscillator period without a CPU clock phase step");

   AST_RISE_TO_HIGH: assert property (@(posedge clk) disable iff (rst)
      prescaleRun ##0 cpuRiseEn |=> cpuClockLevel)
      else $error("rising edge did not raise the clock level");

   AST_FALL_TO_LOW: assert property (@(posedge clk) disable iff (rst)
      prescaleRun ##0 cpuFallEn |=> !cpuClockLevel)
      else $error("falling edge did not lower the clock level");

   AST_NO_DOUBLE_RISE: assert property (@(posedge clk) disable iff (rst)
      prescaleRun ##0 cpuRiseEn |=> !cpuRiseEn)
      else $error("two rising edges in a row in prescaler mode");

   AST_NO_DOUBLE_FALL: assert property (@(posedge clk) disable iff (rst)
      prescaleRun ##0 cpuFallEn |=> !cpuFallEn)
      else $error("two falling edges in a row in prescaler mode");

   AST_HIGH_PHASE_LEN: assert property (@(posedge clk) disable iff (rst)
      prescaleRun |-> highRun <= `PHASE_CNT_W'(`PRESCALE_PHASE_CYCLES))
      else $error("prescaler high phase longer than one oscillator period");

   AST_LOW_PHASE_LEN: assert property (@(posedge clk) disable iff (rst)
      prescaleRun |-> lowRun <= `PHASE_CNT_W'(`PRESCALE_PHASE_CYCLES))
      else $error("prescaler low phase longer than one oscillator period");

endmodule

`default_nettype wire

/* bench/strap_source.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_clock_defines.svh"

module strap_source (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`PORT_BYTE_W-1:0] strap,
   output logic [`PORT_BYTE_W-1:0] pins
);
   // ----------------------------------------
   // Strap drive
   // ----------------------------------------
   logic [`PORT_BYTE_W-1:0] alt;

   // Released lines keep moving, so a late capture cannot hide
   always_ff @(posedge clk) begin
      alt <= rst ? ~strap : ~alt;
   end

   assign pins = rst ? strap : alt;
endmodule

`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_clock_defines.svh"

module testbench;
   import cpu_clock_pkg::*;
   logic clk, rst;
   logic [`PORT_BYTE_W-1:0] strap, pins, cfg;
   logic [`CLK_SEL_W-1:0] sel;
   logic pre, lvl, rise, fall;
   logic [`PHASE_CNT_W-1:0] steps;
   logic [16:0] q[$];
   logic [16:0] e;
   int n_fail, compares, seed;

   // ----------------------------------------
   // Clock, partner and design
   // ----------------------------------------
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   strap_source src_u (.clk(clk), .rst(rst), .strap(strap), .pins(pins));

   cpu_clock_mode_select dut_u (.clk(clk), .rst(rst), .port0UpperByte(pins),
      .resetConfigUpperByte(cfg), .clockSourceSelect(sel), .prescalerMode(pre),
      .cpuClockLevel(lvl), .cpuRiseEn(rise), .cpuFallEn(fall), .phaseSteps(steps));

   // ----------------------------------------
   // Expected outputs, cycle i after release
   // ----------------------------------------
   function automatic logic [16:0] expect_out(input logic [7:0] p, input int i,
      input logic r);
      logic m;
      logic l;
      m = p[`CLK_SEL_MSB];
      l = m ? i[0] : 1'h1;
      if (r) begin
         return {p, p[`CLK_SEL_MSB:`CLK_SEL_LSB], 4'h0, 2'h0};
      end
      return {p, p[`CLK_SEL_MSB:`CLK_SEL_LSB], m, l, ~l | ~m, l, m ? 2'h1 : 2'h2};
   endfunction

   // ----------------------------------------
   // Monitor
   // ----------------------------------------
   always @(negedge clk) begin
      if (q.size() > 0) begin
         e = q.pop_front();
         compares++;
         if ({cfg, sel, pre, lvl, rise, fall, steps} !== e) begin
            n_fail++;
            $display("BAD outputs expected %h seen %h", e,
               {cfg, sel, pre, lvl, rise, fall, steps});
         end
      end
   end

   task automatic stop_test();
      $display("Checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h61F4664C;
      n_fail = 0;
      compares = 0;
      rst = 1'h1;
      strap = 8'h00;
      repeat (2) @(posedge clk);
      // Every select code, random low bits that must not matter
      for (int k = 0; k < 8; k++) begin
         strap <= {k[2:0], 5'($random(seed))};
         repeat (3) @(posedge clk);
         q.push_back(expect_out(strap, 0, 1'h1));
         @(posedge clk);
         rst <= 1'h0;
         // Pins keep changing here and must not reach the capture
         for (int i = 1; i < 7; i++) begin
            @(posedge clk);
            q.push_back(expect_out(strap, i, 1'h0));
         end
         @(posedge clk);
         rst <= 1'h1;
         $display("Test select %0d done", k);
      end
      repeat (2) @(posedge clk);
      stop_test();
   end

   // Hang guard
   initial begin
      repeat (2000) @(posedge clk);
      n_fail++;
      stop_test();
   end
endmodule

`default_nettype wire
